// >>> rtl/hwmes_defines.vh
// Register indices, field positions, reset values and bus codes
`ifndef HWMES_DEFINES_VH
`define HWMES_DEFINES_VH

// Register indices; byte address is four times the index
`define HWMES_IDX_CONFIG        10'h040
`define HWMES_IDX_FLAGS_FIRST   10'h041
`define HWMES_IDX_FLAGS_SECOND  10'h042
`define HWMES_IDX_RAIL12_LOW    10'h04C
`define HWMES_IDX_RAIL12_HIGH   10'h04D
`define HWMES_IDX_TACH_MIN_BASE 10'h054
`define HWMES_IDX_FAN_ENABLE    10'h080
`define HWMES_IDX_TEMP_ENABLE   10'h082
`define HWMES_IDX_DIODE1_READ   10'h0C0
`define HWMES_IDX_DIODE2_READ   10'h0C1
`define HWMES_IDX_IRQ_STATUS    10'h0C2
`define HWMES_IDX_IRQ_MASK      10'h0C3

// Control register fields
`define HWMES_CFG_START         0
`define HWMES_CFG_FAN_GROUP     1
`define HWMES_CFG_TEMP_GROUP    2
`define HWMES_CFG_GLOBAL_EN     3

// Second event register fields, plus the summary bit of the first register
`define HWMES_BIT_RAIL12        0
`define HWMES_BIT_FAN1          2
`define HWMES_BIT_FAN3          4
`define HWMES_BIT_DIODE1        6
`define HWMES_BIT_DIODE2        7
`define HWMES_BIT_SUMMARY       7

// Reset values and forced codes
`define HWMES_FLAGS_RESET       8'h00
`define HWMES_RAIL12_LOW_RESET  8'h00
`define HWMES_RAIL12_HIGH_RESET 8'hFF
`define HWMES_TACH_MIN_RESET    16'hFFFF
`define HWMES_DIODE_FAULT_CODE  8'h80

// Bus response codes
`define HWMES_RESP_OKAY         2'b00
`define HWMES_RESP_SLVERR       2'b10

`endif

// >>> rtl/hwmes_flag_cell.v
// One sticky status flag with enable, start and write-one-to-clear handling
`timescale 1ns/1ns
`include "hwmes_defines.vh"

module hwmes_flag_cell (
  input  wire aclk,
  input  wire aresetn,
  input  wire clear_all,
  input  wire start,
  input  wire enable,
  input  wire event_active,
  input  wire write_one,
  output reg  flag_q
);

  wire set_now;
  wire clr_enable;
  wire clr_write;

  assign set_now    = start & enable & event_active;
  assign clr_enable = start & ~enable;
  assign clr_write  = write_one & ~event_active;

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (clear_all) begin
      flag_q <= 1'b0;
    end else if (set_now) begin
      flag_q <= 1'b1;
    end else if (clr_enable | clr_write) begin
      flag_q <= 1'b0;
    end
  end

endmodule // hwmes_flag_cell

// >>> rtl/hwmes_status_two.v
// Second hardware-monitor event register with AXI4-Lite access
//
// How it works
// - A rising main supply power-good edge returns the whole register to 00h.
// - Writing one clears a flag only once its event has ended; zero does nothing.
// - Fan flags at bits 2-4 set when tach reading exceeds its minimum.
// - Diode fault flags at bits 6 and 7 set on short or open diode.
// - Started monitoring with a diode fault forces 80h into that diode reading.
// - Fan and diode flags stay set until written one, their individual enable is cleared or power-good rises.
// - Writing one never clears a diode fault flag while its fault persists.
// - No event while start is zero or the enable is off.
// - With start one, clearing an enable clears its flag immediately.
// - With start zero, clearing an enable waits until start becomes one.
// - Raising start clears disabled flags; enabled flags are unaffected.
// - Group and global enables never alter the flags here.
// - Fan enables come from register 80h, diode enables from register 82h.
// - Read-only bit 0 shows 12V at or below low or above high limit.
// - Summary flag in the first register follows any flag being set.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "hwmes_defines.vh"

module hwmes_status_two #(
  parameter ADDR_W = 12,
  parameter TACH_W = 16,
  parameter FANS   = 3
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [ADDR_W-1:0]      s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [ADDR_W-1:0]      s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire                   main_supply_power_good,
  input  wire [FANS*TACH_W-1:0] fan_tach_reading,
  input  wire [1:0]             diode_fault,
  input  wire [7:0]             diode_one_temp,
  input  wire [7:0]             diode_two_temp,
  input  wire [7:0]             rail_twelve_reading,
  output reg                    irq,
  output reg                    second_register_summary_flag,
  output reg  [7:0]             diode_one_reading,
  output reg  [7:0]             diode_two_reading
);

  // Address decode shared by the read and write paths
  function hit;
    input [ADDR_W-1:0] addr;
    input [9:0]        idx;
    begin
      hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    end
  endfunction

  reg  [ADDR_W-1:0]      awaddr_q;
  reg  [31:0]            wdata_q;
  reg  [3:0]             wstrb_q;
  reg  [3:0]             config_q;
  reg  [FANS-1:0]        fan_en_q;
  reg  [1:0]             temp_en_q;
  reg  [7:0]             rail_low_q;
  reg  [7:0]             rail_high_q;
  reg  [FANS*TACH_W-1:0] tach_min_q;
  reg                    rail_flag_q;
  reg                    pgood_prev_q;
  reg  [7:0]             flags_prev_q;
  reg  [7:0]             irq_stat_q;
  reg  [7:0]             irq_mask_q;
  reg  [31:0]            rd_data;
  reg                    rd_ok;
  reg                    wr_ok;

  wire                   wr_fire;
  wire                   wr_lo;
  wire                   start;
  wire                   pgood_rise;
  wire                   rail_bad;
  wire [FANS-1:0]        fan_slow;
  wire [4:0]             src_event;
  wire [4:0]             src_en;
  wire [4:0]             src_w1c;
  wire [4:0]             src_flag;
  wire [7:0]             flags;
  wire [7:0]             flags_w1c;
  wire [7:0]             irq_events;

  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_lo   = wr_fire & wstrb_q[0];
  assign start   = config_q[`HWMES_CFG_START];

  assign pgood_rise = main_supply_power_good & ~pgood_prev_q;

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HWMES_RESP_OKAY;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `HWMES_RESP_OKAY : `HWMES_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @* begin
    wr_ok = hit(awaddr_q, `HWMES_IDX_CONFIG) |
            hit(awaddr_q, `HWMES_IDX_FLAGS_FIRST) |
            hit(awaddr_q, `HWMES_IDX_FLAGS_SECOND) |
            hit(awaddr_q, `HWMES_IDX_RAIL12_LOW) |
            hit(awaddr_q, `HWMES_IDX_RAIL12_HIGH) |
            hit(awaddr_q, `HWMES_IDX_FAN_ENABLE) |
            hit(awaddr_q, `HWMES_IDX_TEMP_ENABLE) |
            hit(awaddr_q, `HWMES_IDX_DIODE1_READ) |
            hit(awaddr_q, `HWMES_IDX_DIODE2_READ) |
            hit(awaddr_q, `HWMES_IDX_IRQ_STATUS) |
            hit(awaddr_q, `HWMES_IDX_IRQ_MASK) |
            ((awaddr_q[ADDR_W-1:2] >=
              `HWMES_IDX_TACH_MIN_BASE) &&
             (awaddr_q[ADDR_W-1:2] <
              `HWMES_IDX_TACH_MIN_BASE + FANS));
  end

  // Control, enable and limit registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_q    <= 4'h0;
      fan_en_q    <= {FANS{1'b0}};
      temp_en_q   <= 2'b00;
      rail_low_q  <= `HWMES_RAIL12_LOW_RESET;
      rail_high_q <= `HWMES_RAIL12_HIGH_RESET;
      irq_mask_q  <= 8'h00;
    end else if (wr_lo) begin
      if (hit(awaddr_q, `HWMES_IDX_CONFIG)) begin
        config_q <= wdata_q[3:0];
      end
      if (hit(awaddr_q, `HWMES_IDX_FAN_ENABLE)) begin
        fan_en_q <= wdata_q[FANS-1:0];
      end
      if (hit(awaddr_q, `HWMES_IDX_TEMP_ENABLE)) begin
        temp_en_q <= wdata_q[1:0];
      end
      if (hit(awaddr_q, `HWMES_IDX_RAIL12_LOW)) begin
        rail_low_q <= wdata_q[7:0];
      end
      if (hit(awaddr_q, `HWMES_IDX_RAIL12_HIGH)) begin
        rail_high_q <= wdata_q[7:0];
      end
      if (hit(awaddr_q, `HWMES_IDX_IRQ_MASK)) begin
        irq_mask_q <= wdata_q[7:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < FANS; gi = gi + 1) begin : g_fan
      wire [31:0] tach_idx;

      assign tach_idx = `HWMES_IDX_TACH_MIN_BASE + gi;

      assign fan_slow[gi] =
        fan_tach_reading[gi*TACH_W +: TACH_W] >
        tach_min_q[gi*TACH_W +: TACH_W];

      always @(posedge aclk) begin
        if (!aresetn) begin
          tach_min_q[gi*TACH_W +: TACH_W] <= `HWMES_TACH_MIN_RESET;
        end else if (wr_fire &&
                     hit(awaddr_q, tach_idx[9:0])) begin
          if (wstrb_q[0]) begin
            tach_min_q[gi*TACH_W +: 8] <= wdata_q[7:0];
          end
          if (wstrb_q[1]) begin
            tach_min_q[gi*TACH_W+8 +: TACH_W-8] <= wdata_q[TACH_W-1:8];
          end
        end
      end
    end
  endgenerate

  // Writes of one to the second event register, low lane only
  assign flags_w1c = (wr_lo && hit(awaddr_q, `HWMES_IDX_FLAGS_SECOND)) ?
                     wdata_q[7:0] : 8'h00;

  assign src_event = {diode_fault, fan_slow};
  assign src_en    = {temp_en_q, fan_en_q};
  assign src_w1c   = {flags_w1c[`HWMES_BIT_DIODE2:`HWMES_BIT_DIODE1],
                      flags_w1c[`HWMES_BIT_FAN3:`HWMES_BIT_FAN1]};

  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
      hwmes_flag_cell u_cell (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .clear_all    (pgood_rise),
        .start        (start),
        .enable       (src_en[gi]),
        .event_active (src_event[gi]),
        .write_one    (src_w1c[gi]),
        .flag_q       (src_flag[gi])
      );
    end
  endgenerate

  assign rail_bad = (rail_twelve_reading <= rail_low_q) |
                    (rail_twelve_reading > rail_high_q);

  assign flags = {src_flag[4:3], 1'b0, src_flag[2:0], 1'b0, rail_flag_q};

  assign irq_events = flags & ~flags_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pgood_prev_q <= 1'b0;
      rail_flag_q  <= 1'b0;
      flags_prev_q <= `HWMES_FLAGS_RESET;
      irq_stat_q   <= 8'h00;
      irq          <= 1'b0;
      second_register_summary_flag <= 1'b0;
      diode_one_reading <= 8'h00;
      diode_two_reading <= 8'h00;
    end else begin
      pgood_prev_q <= main_supply_power_good;
      flags_prev_q <= flags;
      if (pgood_rise) begin
        rail_flag_q <= 1'b0;
      end else if (start) begin
        rail_flag_q <= rail_bad;
      end
      // Event set wins over a clearing write in the same cycle
      if (wr_lo && hit(awaddr_q, `HWMES_IDX_IRQ_STATUS)) begin
        irq_stat_q <= irq_events | (irq_stat_q & ~wdata_q[7:0]);
      end else begin
        irq_stat_q <= irq_events | irq_stat_q;
      end
      irq <= config_q[`HWMES_CFG_GLOBAL_EN] & (|(irq_stat_q & irq_mask_q));
      second_register_summary_flag <= |flags;
      diode_one_reading <= (start & diode_fault[0]) ?
                           `HWMES_DIODE_FAULT_CODE : diode_one_temp;
      diode_two_reading <= (start & diode_fault[1]) ?
                           `HWMES_DIODE_FAULT_CODE : diode_two_temp;
    end
  end

  // Read data selection
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (hit(s_axi_araddr, `HWMES_IDX_CONFIG)) begin
      rd_data[3:0] = config_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_FLAGS_FIRST)) begin
      rd_data[`HWMES_BIT_SUMMARY] = second_register_summary_flag;
    end else if (hit(s_axi_araddr, `HWMES_IDX_FLAGS_SECOND)) begin
      rd_data[7:0] = flags;
    end else if (hit(s_axi_araddr, `HWMES_IDX_RAIL12_LOW)) begin
      rd_data[7:0] = rail_low_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_RAIL12_HIGH)) begin
      rd_data[7:0] = rail_high_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_FAN_ENABLE)) begin
      rd_data[FANS-1:0] = fan_en_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_TEMP_ENABLE)) begin
      rd_data[1:0] = temp_en_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_DIODE1_READ)) begin
      rd_data[7:0] = diode_one_reading;
    end else if (hit(s_axi_araddr, `HWMES_IDX_DIODE2_READ)) begin
      rd_data[7:0] = diode_two_reading;
    end else if (hit(s_axi_araddr, `HWMES_IDX_IRQ_STATUS)) begin
      rd_data[7:0] = irq_stat_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_IRQ_MASK)) begin
      rd_data[7:0] = irq_mask_q;
    end else if (hit(s_axi_araddr, `HWMES_IDX_TACH_MIN_BASE)) begin
      rd_data[TACH_W-1:0] = tach_min_q[TACH_W-1:0];
    end else if (hit(s_axi_araddr, `HWMES_IDX_TACH_MIN_BASE + 10'h001)) begin
      rd_data[TACH_W-1:0] = tach_min_q[TACH_W +: TACH_W];
    end else if (hit(s_axi_araddr, `HWMES_IDX_TACH_MIN_BASE + 10'h002)) begin
      rd_data[TACH_W-1:0] = tach_min_q[2*TACH_W +: TACH_W];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read channel: one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `HWMES_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `HWMES_RESP_OKAY : `HWMES_RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // hwmes_status_two

// >>> verif/hwmes_status_two_properties.sv
// Bus and reading checks for the second event register block
`timescale 1ns/1ns
`include "hwmes_defines.vh"
module hwmes_status_two_properties #(
  parameter ADDR_W = 12,
  parameter TACH_W = 16,
  parameter FANS   = 3
) (
  input logic              aclk,
  input logic              aresetn,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  input logic [1:0]        diode_fault,
  input logic [7:0]        diode_one_temp,
  input logic [7:0]        diode_two_temp,
  input logic [7:0]        diode_one_reading,
  input logic [7:0]        diode_two_reading
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges later");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_wr_busy: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_rd_unmapped: assert property (s_rd_take and (s_axi_araddr == 12'hFFC)
    |=> s_axi_rresp == `HWMES_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  chk_one_follow: assert property (!diode_fault[0]
    |=> diode_one_reading == $past(diode_one_temp))
    else $error("diode one reading not following input");
  chk_two_follow: assert property (!diode_fault[1]
    |=> diode_two_reading == $past(diode_two_temp))
    else $error("diode two reading not following input");
endmodule // hwmes_status_two_properties

bind hwmes_status_two hwmes_status_two_properties #(
  .ADDR_W(ADDR_W), .TACH_W(TACH_W), .FANS(FANS)) chk_u (.*);

// >>> verif/hwmes_status_two_tb_top.sv
// Self-checking bench for the second event register block
`timescale 1ns/1ns
`include "hwmes_defines.vh"
module hwmes_status_two_tb_top;
  typedef struct packed {
    logic [47:0] fan;
    logic [1:0]  fault;
    logic [7:0]  rail;
    logic [7:0]  flags;
  } hwmes_row_t;
  localparam logic [15:0] LO = 16'h0080;
  localparam logic [15:0] HI = 16'h0200;
  logic        aclk, aresetn, irq, main_supply_power_good;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, diode_fault, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, second_register_summary_flag;
  logic [47:0] fan_tach_reading;
  logic [7:0]  diode_one_temp, diode_two_temp, rail_twelve_reading;
  logic [7:0]  diode_one_reading, diode_two_reading;
  int          err_total, num_checks, lag;
  hwmes_row_t  rows [7];

  hwmes_status_two dut_u (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task cmp_val(input logic [31:0] got, input logic [31:0] exp,
               input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ap, wp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && s_axi_awready === 1'b1) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready === 1'b1) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (lag > 0) begin
      repeat (lag) @(posedge aclk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd_reg(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if (lag > 0) begin
      repeat (lag) @(posedge aclk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task flags(input logic [7:0] e);
    rd_reg(12'h108);
    cmp_val(rd, {24'h000000, e}, "event flags");
  endtask

  task settle;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim;
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    main_supply_power_good = 1'b1;
    diode_fault = 2'h0;
    fan_tach_reading = {LO, LO, LO};
    diode_one_temp = 8'h3C;
    diode_two_temp = 8'h2A;
    rail_twelve_reading = 8'h80;
    err_total = 0;
    num_checks = 0;
    lag = 0;
    rows[0] = '{48'h0100_0100_0100, 2'h0, 8'h80, 8'h00};
    rows[1] = '{{LO, LO, HI}, 2'h0, 8'h80, 8'h04};
    rows[2] = '{{LO, LO, LO}, 2'h0, 8'h80, 8'h04};
    rows[3] = '{{LO, LO, LO}, 2'h1, 8'h80, 8'h44};
    rows[4] = '{{LO, LO, LO}, 2'h1, 8'h00, 8'h45};
    rows[5] = '{{LO, LO, LO}, 2'h1, 8'hFF, 8'h44};
    rows[6] = '{{LO, LO, LO}, 2'h2, 8'hFF, 8'hC4};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    flags(8'h00);
    rd_reg(12'hFFC);
    cmp_val(rs, `HWMES_RESP_SLVERR, "unmapped read");
    wr(12'hFFC, 32'h00000001);
    cmp_val(rs, `HWMES_RESP_SLVERR, "unmapped write");
    wr(12'h150, 32'h00000100);
    wr(12'h154, 32'h00000100);
    wr(12'h158, 32'h00000100);
    wr(12'h200, 32'h00000007);
    wr(12'h208, 32'h00000003);
    wr(12'h100, 32'h00000001);
    foreach (rows[i]) begin
      fan_tach_reading <= rows[i].fan;
      diode_fault <= rows[i].fault;
      rail_twelve_reading <= rows[i].rail;
      settle();
      flags(rows[i].flags);
      cmp_val(second_register_summary_flag, |rows[i].flags, "summary");
    end
    wr(12'h108, 32'h000000FF);
    flags(8'h80);
    wr(12'h108, 32'h00000000);
    flags(8'h80);
    cmp_val(diode_one_reading, 8'h3C, "plain reading");
    cmp_val(diode_two_reading, 8'h80, "forced code");
    wr(12'h30C, 32'h000000FF);
    wr(12'h100, 32'h00000009);
    settle();
    cmp_val(irq, 1'b1, "irq raised");
    wr(12'h30C, 32'h00000000);
    settle();
    cmp_val(irq, 1'b0, "irq masked");
    wr(12'h30C, 32'h000000FF);
    wr(12'h308, 32'h000000FF);
    settle();
    cmp_val(irq, 1'b0, "irq cleared");
    wr(12'h100, 32'h00000007);
    wr(12'h100, 32'h00000001);
    flags(8'h80);
    wr(12'h208, 32'h00000000);
    flags(8'h00);
    diode_fault <= 2'h0;
    fan_tach_reading <= {LO, HI, LO};
    settle();
    flags(8'h08);
    wr(12'h100, 32'h00000000);
    fan_tach_reading <= {HI, HI, LO};
    settle();
    flags(8'h08);
    wr(12'h200, 32'h00000000);
    flags(8'h08);
    wr(12'h100, 32'h00000001);
    flags(8'h00);
    wr(12'h200, 32'h00000007);
    settle();
    flags(8'h18);
    fan_tach_reading <= {LO, LO, LO};
    main_supply_power_good <= 1'b0;
    settle();
    main_supply_power_good <= 1'b1;
    settle();
    flags(8'h00);
    diode_one_temp <= 8'h55;
    lag = 3;
    wr(12'h130, 32'h00000010);
    rd_reg(12'h130);
    lag = 0;
    cmp_val(rd, 32'h00000010, "low limit");
    cmp_val(diode_one_reading, 8'h55, "reading follows");
    rail_twelve_reading <= 8'h10;
    settle();
    flags(8'h01);
    end_sim;
  end
endmodule // hwmes_status_two_tb_top
